// [design/lpd_map.vh]
/*
 Constants for the four-output lamp dimmer: register indices, field positions,
 reset values and timing counts. Assumes a 10 MHz system clock.
*/
`ifndef LPD_MAP_VH
`define LPD_MAP_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define LPD_CLK_HZ 10000000
`define LPD_OSC_HZ 400000
`define LPD_OSC_DIV (`LPD_CLK_HZ / `LPD_OSC_HZ)
`define LPD_BLINK_STEP 6'h00
`define LPD_DIM_STEP 15'h0008
`define LPD_FINE_BLINK_MAX 8'h03

// ----------------------------------------
// Register indices
// ----------------------------------------
`define LPD_R_MODE1 4'h0
`define LPD_R_MODE2 4'h1
`define LPD_R_PWM0 4'h2
`define LPD_R_PWM3 4'h5
`define LPD_R_GRPPWM 4'h6
`define LPD_R_GRPFREQ 4'h7
`define LPD_R_LEDOUT 4'h8
`define LPD_R_SUB1 4'h9
`define LPD_R_SUB2 4'ha
`define LPD_R_SUB3 4'hb
`define LPD_R_ALLCALL 4'hc
`define LPD_R_LAST 4'hc

// ----------------------------------------
// Fields
// ----------------------------------------
`define LPD_M1_ALLCALL 0
`define LPD_M1_SUB3 1
`define LPD_M1_SUB2 2
`define LPD_M1_SUB1 3
`define LPD_M2_OUTDRV 2
`define LPD_M2_OCH 3
`define LPD_M2_DMBLNK 5
`define LPD_LS_OFF 2'h0
`define LPD_LS_ON 2'h1
`define LPD_LS_PWM 2'h2
`define LPD_LS_GRP 2'h3

// ----------------------------------------
// Reset values and bus codes
// ----------------------------------------
`define LPD_RST_MODE1 8'h01
`define LPD_RST_MODE2 8'h00
`define LPD_RST_PWM 8'h00
`define LPD_RST_GRPPWM 8'hff
`define LPD_RST_GRPFREQ 8'h00
`define LPD_RST_LEDOUT 8'h00
`define LPD_RST_SUB1 8'he2
`define LPD_RST_SUB2 8'he4
`define LPD_RST_SUB3 8'he8
`define LPD_RST_ALLCALL 8'he0
`define LPD_GCALL 8'h00
`define LPD_RESET_CODE 8'h06

`endif

// [design/lpd_dimmer.v]
/*
 Four-output lamp PWM dimmer with a two-wire serial slave port, register file,
 individual and group PWM engines and output stage.
 Assumes scl_in/sda_in come straight from pins (synchronised here) and that the
 pad ring resolves sda from sda_oe and each lamp pin from its enable.
*/
`timescale 1ns/100ps
`include "lpd_map.vh"

// How it works
// RQ1: Individual mode: 8-bit per-output PWM, 256 ticks, 1.5625 kHz.
// RQ2: Group dim mode with any output in group state: per-output PWM cut to 6 bits, 64 ticks, 6.25 kHz.
// RQ3: Group dim mode: shared 16-step group PWM near 195 Hz dims outputs in group state.
// RQ4: Blink mode keeps per-output PWM at 8 bits and 1.5625 kHz.
// RQ5: Blink period set by 8-bit group frequency, 24 Hz to 10.49 s.
// RQ6: Fast blink settings use 6-bit group duty.
// RQ7: Slow blink settings use full 8-bit group duty.
// RQ8: Each output is off, on, own PWM, or own PWM with group.
// RQ9: Output stage selectable open-drain or totem-pole.
// RQ10: Reset call on the bus restores all power-on defaults.
// RQ11: Outputs update on each acknowledge or at stop; stop is default.
// RQ12: Brightness linear in value; defaults to fully off.
// RQ13: Group dimming defaults to maximum brightness.
// RQ14: Outputs high-impedance after reset; drivers only.
// RQ15: Timing derived from an internal 400 kHz tick.
// RQ16: Slave port handles bus clock up to 1 MHz.
// RQ17: Answers own, broadcast and three sub-group addresses.
// RQ18: Reset call acknowledged only in write direction.
// RQ19: Last address bit selects read (1) or write (0).
// RQ20: Broadcast address enabled at power-up, default E0h, read or write.
// RQ21: Duty values change only at a period boundary.
// RQ22: Combined output active only while both PWMs active.
module lpd_dimmer #(
	parameter [6:0] SLAVE_ADDR = 7'h62
) (
	input wire clk,
	input wire nrst,
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	output wire lamp_drive_0_out,
	output wire lamp_drive_0_oe,
	output wire lamp_drive_1_out,
	output wire lamp_drive_1_oe,
	output wire lamp_drive_2_out,
	output wire lamp_drive_2_oe,
	output wire lamp_drive_3_out,
	output wire lamp_drive_3_oe
);

localparam ST_IDLE = 5'b00001;
localparam ST_RX = 5'b00010;
localparam ST_ACK = 5'b00100;
localparam ST_TX = 5'b01000;
localparam ST_RACK = 5'b10000;

function [7:0] rst_val;
	input [3:0] a;
	begin
		case (a)
		`LPD_R_MODE1: rst_val = `LPD_RST_MODE1;
		`LPD_R_MODE2: rst_val = `LPD_RST_MODE2;
		`LPD_R_GRPPWM: rst_val = `LPD_RST_GRPPWM;
		`LPD_R_GRPFREQ: rst_val = `LPD_RST_GRPFREQ;
		`LPD_R_LEDOUT: rst_val = `LPD_RST_LEDOUT;
		`LPD_R_SUB1: rst_val = `LPD_RST_SUB1;
		`LPD_R_SUB2: rst_val = `LPD_RST_SUB2;
		`LPD_R_SUB3: rst_val = `LPD_RST_SUB3;
		`LPD_R_ALLCALL: rst_val = `LPD_RST_ALLCALL;
		default: rst_val = `LPD_RST_PWM;
		endcase
	end
endfunction

// Pointer step after each data byte; windows wrap to their first register
function [3:0] next_ptr;
	input [3:0] p;
	input [2:0] ai;
	reg [3:0] first;
	reg [3:0] last;
	begin
		first = `LPD_R_PWM0;
		last = `LPD_R_GRPFREQ;
		case (ai[1:0])
		2'h1: last = `LPD_R_PWM3;
		2'h2: first = `LPD_R_GRPPWM;
		default: first = `LPD_R_PWM0;
		endcase
		if (!ai[2])
			next_ptr = p;
		else if (p >= `LPD_R_LAST)
			next_ptr = 4'h0;
		else if (ai[1:0] != 2'h0 && p == last)
			next_ptr = first;
		else
			next_ptr = p + 4'h1;
	end
endfunction

// ----------------------------------------
// Pin synchronisers and bus events
// ----------------------------------------
reg scl_m_r, scl_r, scl_d_r, sda_m_r, sda_r, sda_d_r;
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		scl_m_r <= 1'b1;
		scl_r <= 1'b1;
		scl_d_r <= 1'b1;
		sda_m_r <= 1'b1;
		sda_r <= 1'b1;
		sda_d_r <= 1'b1;
	end
	else
	begin
		scl_m_r <= scl_in;
		scl_r <= scl_m_r;
		scl_d_r <= scl_r;
		sda_m_r <= sda_in;
		sda_r <= sda_m_r;
		sda_d_r <= sda_r;
	end
end

// 5 clocks per half period at 1 MHz, so every bus edge is seen RQ16
wire rise = scl_r & ~scl_d_r;
wire fall = ~scl_r & scl_d_r;
wire start = scl_r & scl_d_r & sda_d_r & ~sda_r;
wire stop = scl_r & scl_d_r & ~sda_d_r & sda_r;

// ----------------------------------------
// Serial slave and register file
// ----------------------------------------
reg [7:0] regs [0:12];
reg [4:0] st_r;
reg [2:0] bit_r;
reg full_r, rd_r, gc_r, nack_r, wrote_r, upd_r, bus_reset_call_r, sda_oe_r;
reg [1:0] bidx_r;
reg [7:0] sh_r, tx_r;
reg [3:0] ptr_r;
reg [2:0] ai_r;
reg ev_ack;
integer i;

wire [7:0] mode1 = regs[`LPD_R_MODE1];
wire och = regs[`LPD_R_MODE2][`LPD_M2_OCH];
wire [7:0] rdata = (ptr_r <= `LPD_R_LAST) ? regs[ptr_r] : 8'h00;

always @*
begin
	ev_ack = 1'b0;
	case (bidx_r)
	2'h0: ev_ack = (sh_r == `LPD_GCALL) || (sh_r[7:1] == SLAVE_ADDR) || //RQ18
		(mode1[`LPD_M1_ALLCALL] && sh_r[7:1] == regs[`LPD_R_ALLCALL][7:1]) || //RQ20
		(mode1[`LPD_M1_SUB1] && sh_r[7:1] == regs[`LPD_R_SUB1][7:1]) || //RQ17
		(mode1[`LPD_M1_SUB2] && sh_r[7:1] == regs[`LPD_R_SUB2][7:1]) ||
		(mode1[`LPD_M1_SUB3] && sh_r[7:1] == regs[`LPD_R_SUB3][7:1]);
	2'h1: ev_ack = gc_r ? (sh_r == `LPD_RESET_CODE) : 1'b1;
	default: ev_ack = ~gc_r;
	endcase
end

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		for (i = 0; i <= 12; i = i + 1)
			regs[i] <= rst_val(i[3:0]);
		st_r <= ST_IDLE;
		bit_r <= 3'h0;
		full_r <= 1'b0;
		rd_r <= 1'b0;
		gc_r <= 1'b0;
		nack_r <= 1'b0;
		wrote_r <= 1'b0;
		upd_r <= 1'b0;
		bus_reset_call_r <= 1'b0;
		sda_oe_r <= 1'b0;
		bidx_r <= 2'h0;
		sh_r <= 8'h00;
		tx_r <= 8'h00;
		ptr_r <= 4'h0;
		ai_r <= 3'h0;
	end
	else
	begin
		upd_r <= 1'b0;
		bus_reset_call_r <= 1'b0;
		if (bus_reset_call_r)
		begin
			for (i = 0; i <= 12; i = i + 1)
				regs[i] <= rst_val(i[3:0]); //RQ10
			ptr_r <= 4'h0;
			ai_r <= 3'h0;
		end
		if (start)
		begin
			st_r <= ST_RX;
			bit_r <= 3'h0;
			full_r <= 1'b0;
			bidx_r <= 2'h0;
			gc_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end
		else if (stop)
		begin
			st_r <= ST_IDLE;
			sda_oe_r <= 1'b0;
			wrote_r <= 1'b0;
			if (wrote_r && !och)
				upd_r <= 1'b1; //RQ11
		end
		else
		case (st_r)
		ST_RX:
			if (rise)
			begin
				sh_r <= {sh_r[6:0], sda_r};
				bit_r <= bit_r + 3'h1;
				full_r <= (bit_r == 3'h7);
			end
			else if (fall && full_r)
			begin
				full_r <= 1'b0;
				sda_oe_r <= ev_ack;
				st_r <= ev_ack ? ST_ACK : ST_IDLE;
				if (bidx_r != 2'h2)
					bidx_r <= bidx_r + 2'h1;
				if (bidx_r == 2'h0)
				begin
					rd_r <= sh_r[0]; //RQ19
					gc_r <= (sh_r == `LPD_GCALL);
				end
				else if (bidx_r == 2'h1 && gc_r)
					bus_reset_call_r <= ev_ack;
				else if (bidx_r == 2'h1)
				begin
					ptr_r <= sh_r[3:0];
					ai_r <= sh_r[7:5];
				end
				else if (ev_ack)
				begin
					if (ptr_r <= `LPD_R_LAST)
						regs[ptr_r] <= sh_r;
					ptr_r <= next_ptr(ptr_r, ai_r);
					wrote_r <= 1'b1;
					upd_r <= och; //RQ11
				end
			end
		ST_ACK:
			if (fall)
			begin
				bit_r <= 3'h0;
				if (rd_r)
				begin
					st_r <= ST_TX;
					tx_r <= rdata;
					sda_oe_r <= ~rdata[7];
					ptr_r <= next_ptr(ptr_r, ai_r);
				end
				else
				begin
					st_r <= ST_RX;
					sda_oe_r <= 1'b0;
				end
			end
		ST_TX:
			if (fall)
			begin
				if (bit_r == 3'h7)
				begin
					st_r <= ST_RACK;
					sda_oe_r <= 1'b0;
				end
				else
				begin
					tx_r <= {tx_r[6:0], 1'b0};
					sda_oe_r <= ~tx_r[6];
					bit_r <= bit_r + 3'h1;
				end
			end
		ST_RACK:
			if (rise)
				nack_r <= sda_r;
			else if (fall && nack_r)
				st_r <= ST_IDLE;
			else if (fall)
			begin
				st_r <= ST_TX;
				bit_r <= 3'h0;
				tx_r <= rdata;
				sda_oe_r <= ~rdata[7];
				ptr_r <= next_ptr(ptr_r, ai_r);
			end
		ST_IDLE:
			sda_oe_r <= 1'b0;
		default:
			st_r <= ST_IDLE;
		endcase
	end
end

assign sda_out = 1'b0;
assign sda_oe = sda_oe_r;

// ----------------------------------------
// Live copies seen by the PWM engines
// ----------------------------------------
reg [7:0] mode2_l, grppwm_l, grpfreq_l, ledout_l;
reg [7:0] pwm_l [0:3];
integer j;
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		mode2_l <= `LPD_RST_MODE2;
		grppwm_l <= `LPD_RST_GRPPWM; //RQ13
		grpfreq_l <= `LPD_RST_GRPFREQ;
		ledout_l <= `LPD_RST_LEDOUT; //RQ14
		for (j = 0; j < 4; j = j + 1)
			pwm_l[j] <= `LPD_RST_PWM; //RQ12
	end
	else if (bus_reset_call_r)
	begin
		mode2_l <= `LPD_RST_MODE2; //RQ10
		grppwm_l <= `LPD_RST_GRPPWM;
		grpfreq_l <= `LPD_RST_GRPFREQ;
		ledout_l <= `LPD_RST_LEDOUT;
		for (j = 0; j < 4; j = j + 1)
			pwm_l[j] <= `LPD_RST_PWM;
	end
	else if (upd_r)
	begin
		mode2_l <= regs[`LPD_R_MODE2];
		grppwm_l <= regs[`LPD_R_GRPPWM];
		grpfreq_l <= regs[`LPD_R_GRPFREQ];
		ledout_l <= regs[`LPD_R_LEDOUT];
		for (j = 0; j < 4; j = j + 1)
			pwm_l[j] <= regs[`LPD_R_PWM0 + j[3:0]];
	end
end

// ----------------------------------------
// Oscillator tick and PWM engines
// ----------------------------------------
localparam [31:0] OSC_LAST_W = `LPD_OSC_DIV - 1;
localparam [4:0] OSC_LAST = OSC_LAST_W[4:0];
// Dim mode keeps only the top four duty bits, so start there after reset
localparam [7:0] GP_DUTY_RST = `LPD_RST_GRPPWM & 8'hf0;
wire blink = mode2_l[`LPD_M2_DMBLNK];
wire any_grp = (ledout_l[1:0] == `LPD_LS_GRP) || (ledout_l[3:2] == `LPD_LS_GRP) ||
	(ledout_l[5:4] == `LPD_LS_GRP) || (ledout_l[7:6] == `LPD_LS_GRP);
wire [14:0] gp_len = blink ? {({1'b0, grpfreq_l} + 9'h001), `LPD_BLINK_STEP} : `LPD_DIM_STEP; //RQ5
wire [7:0] gp_duty = !blink ? {grppwm_l[7:4], 4'h0} : //RQ3
	(grpfreq_l <= `LPD_FINE_BLINK_MAX) ? {grppwm_l[7:2], 2'h0} : grppwm_l; //RQ6 RQ7

reg [4:0] osc_r;
reg [7:0] ip_cnt_r, gp_step_r, gp_duty_r;
reg [14:0] gp_div_r, gp_len_r;
reg fine6_r;
reg [7:0] duty_r [0:3];
integer k;
wire tick = (osc_r == OSC_LAST); //RQ15
wire ip_end = tick && (fine6_r ? (ip_cnt_r[5:0] == 6'h3f) : (ip_cnt_r == 8'hff));
wire gp_end = tick && (gp_div_r == gp_len_r - 15'h0001);
wire gp_act = gp_step_r < gp_duty_r;

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		osc_r <= 5'h00;
		ip_cnt_r <= 8'h00;
		fine6_r <= 1'b0;
		gp_div_r <= 15'h0000;
		gp_len_r <= `LPD_DIM_STEP;
		gp_step_r <= 8'h00;
		gp_duty_r <= GP_DUTY_RST;
		for (k = 0; k < 4; k = k + 1)
			duty_r[k] <= `LPD_RST_PWM;
	end
	else
	begin
		osc_r <= tick ? 5'h00 : osc_r + 5'h01;
		if (ip_end)
		begin
			ip_cnt_r <= 8'h00;
			fine6_r <= ~blink & any_grp; //RQ2 RQ4
			for (k = 0; k < 4; k = k + 1)
				duty_r[k] <= pwm_l[k]; //RQ21
		end
		else if (tick)
			ip_cnt_r <= ip_cnt_r + 8'h01; //RQ1
		if (gp_end)
		begin
			gp_div_r <= 15'h0000;
			gp_step_r <= gp_step_r + 8'h01;
			if (gp_step_r == 8'hff)
			begin
				gp_len_r <= gp_len; //RQ21
				gp_duty_r <= gp_duty;
			end
		end
		else if (tick)
			gp_div_r <= gp_div_r + 15'h0001;
	end
end

// ----------------------------------------
// Output stage
// ----------------------------------------
// Active means the lamp pin sinks current; open-drain just floats when idle
reg [3:0] out_r, oe_r;
reg [3:0] act_v;
integer n;

// Own PWM compare; in 6-bit mode only the top six duty bits count
function own_on;
	input [7:0] cnt;
	input [7:0] duty;
	input fine;
	begin
		if (fine)
			own_on = cnt < {2'h0, duty[7:2]};
		else
			own_on = cnt < duty;
	end
endfunction

always @*
begin
	act_v = 4'h0;
	for (n = 0; n < 4; n = n + 1)
	begin
		case (ledout_l[2 * n +: 2]) //RQ8
		`LPD_LS_ON: act_v[n] = 1'b1;
		`LPD_LS_PWM: act_v[n] = own_on(ip_cnt_r, duty_r[n], fine6_r); //RQ12
		`LPD_LS_GRP: act_v[n] = gp_act && own_on(ip_cnt_r, duty_r[n], fine6_r); //RQ22
		default: act_v[n] = 1'b0;
		endcase
	end
end

// Idle pins show high in both stages, the same as during reset
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		out_r <= 4'hf;
		oe_r <= 4'h0; //RQ14
	end
	else
	begin
		out_r <= ~act_v;
		oe_r <= mode2_l[`LPD_M2_OUTDRV] ? 4'hf : act_v; //RQ9
	end
end

assign lamp_drive_0_out = out_r[0];
assign lamp_drive_0_oe = oe_r[0];
assign lamp_drive_1_out = out_r[1];
assign lamp_drive_1_oe = oe_r[1];
assign lamp_drive_2_out = out_r[2];
assign lamp_drive_2_oe = oe_r[2];
assign lamp_drive_3_out = out_r[3];
assign lamp_drive_3_oe = oe_r[3];

endmodule

// [testbench/lpd_dimmer_asserts.sv]
/*
 Port checker for lpd_dimmer, bound to every instance.
 Assumes a bus master that holds scl at least 4 clk high and 4 clk low.
*/
`timescale 1ns/100ps
module lpd_dimmer_asserts (
	input wire clk,
	input wire nrst,
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	input wire lamp_drive_0_out,
	input wire lamp_drive_0_oe,
	input wire lamp_drive_1_out,
	input wire lamp_drive_1_oe,
	input wire lamp_drive_2_out,
	input wire lamp_drive_2_oe,
	input wire lamp_drive_3_out,
	input wire lamp_drive_3_oe
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// --------
	// Serial port
	// --------
	property p_sda_od;
		sda_out == 1'b0;
	endproperty
	a_sda_od: assert property (p_sda_od) else $error("sda driven high");
	property p_sda_rst;
		$rose(nrst) |-> (!sda_oe) [*3];
	endproperty
	a_sda_rst: assert property (p_sda_rst) else $error("sda pulled after reset");
	// Ack and data may only move while the clock is low
	property p_sda_edge;
		$changed(sda_oe) |-> !$past(scl_in, 2);
	endproperty
	a_sda_edge: assert property (p_sda_edge) else $error("sda moved in clock high");
	property p_sda_hold;
		$changed(sda_oe) |=> $stable(sda_oe) [*3];
	endproperty
	a_sda_hold: assert property (p_sda_hold) else $error("sda bit too short");
	property p_sda_idle;
		scl_in [*8] |-> !sda_oe;
	endproperty
	a_sda_idle: assert property (p_sda_idle) else $error("sda held on idle bus");
	// --------
	// Lamp pins
	// --------
	property p_lamp_rst;
		$rose(nrst) |-> (!(lamp_drive_0_oe || lamp_drive_1_oe || lamp_drive_2_oe || lamp_drive_3_oe)) [*8];
	endproperty
	a_lamp_rst: assert property (p_lamp_rst) else $error("lamp driven after reset");
	// Driven high means push-pull, which is shared by all lamps
	property p_totem0;
		lamp_drive_0_oe && lamp_drive_0_out |-> lamp_drive_1_oe && lamp_drive_2_oe && lamp_drive_3_oe;
	endproperty
	a_totem0: assert property (p_totem0) else $error("stage mix on lamp 0");
	property p_totem3;
		lamp_drive_3_oe && lamp_drive_3_out |-> lamp_drive_0_oe && lamp_drive_1_oe && lamp_drive_2_oe;
	endproperty
	a_totem3: assert property (p_totem3) else $error("stage mix on lamp 3");
endmodule

bind lpd_dimmer lpd_dimmer_asserts chk (
	.clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.lamp_drive_0_out(lamp_drive_0_out), .lamp_drive_0_oe(lamp_drive_0_oe),
	.lamp_drive_1_out(lamp_drive_1_out), .lamp_drive_1_oe(lamp_drive_1_oe),
	.lamp_drive_2_out(lamp_drive_2_out), .lamp_drive_2_oe(lamp_drive_2_oe),
	.lamp_drive_3_out(lamp_drive_3_out), .lamp_drive_3_oe(lamp_drive_3_oe)
);

// [testbench/lpd_i2c_master.sv]
/*
 Two-wire bus master model: start, stop, byte out, byte in.
 Assumes the slave pulls sda low through sda_oe; the line has a pull-up.
*/
`timescale 1ns/100ps
module lpd_i2c_master (
	input wire clk,
	input wire sda_oe,
	output reg scl,
	output wire sda
);
	reg drv;
	// Released line floats to the pull-up level
	assign sda = sda_oe ? 1'b0 : drv;
	initial
	begin
		scl = 1'b1;
		drv = 1'b1;
	end
	task tk(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// Clock stays still outside frames; 8 clk per bit
	task bit_io(input b, output r);
	begin
		tk(2);
		drv <= b;
		tk(2);
		scl <= 1'b1;
		tk(2);
		r = sda;
		tk(2);
		scl <= 1'b0;
	end
	endtask
	task start;
	begin
		tk(2);
		drv <= 1'b1;
		tk(2);
		scl <= 1'b1;
		tk(4);
		drv <= 1'b0;
		tk(4);
		scl <= 1'b0;
	end
	endtask
	task stop;
	begin
		tk(2);
		drv <= 1'b0;
		tk(2);
		scl <= 1'b1;
		tk(4);
		drv <= 1'b1;
		tk(4);
	end
	endtask
	task put(input [7:0] b, output ack);
		integer i;
		reg r;
	begin
		for (i = 7; i >= 0; i = i - 1)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	end
	endtask
	task get(input nack, output [7:0] d);
		integer i;
		reg r;
	begin
		for (i = 7; i >= 0; i = i - 1)
			bit_io(1'b1, d[i]);
		bit_io(nack, r);
	end
	endtask
endmodule

// [testbench/lpd_dimmer_tb.sv]
/*
 Self-checking bench for lpd_dimmer: register access, lamp states, PWM duty.
 Assumes a 10 MHz clk and the bus master model on the serial port.
*/
`timescale 1ns/100ps
module lpd_dimmer_tb;
	localparam [103:0] DFLT = 104'h01_00_00000000_ff_00_00_e2e4e8e0;
	localparam [31:0] ADRS = 32'hc4_e0_e2_01;
	localparam [3:0] ACKS = 4'b1100;
	reg clk;
	reg nrst;
	wire scl;
	wire sda;
	wire sda_out;
	wire sda_oe;
	wire [3:0] lo;
	wire [3:0] le;
	integer n_mismatch = 0;
	integer checked = 0;
	integer i;
	integer k;
	reg a;
	reg [7:0] d;
	initial clk = 1'b0;
	always #50 clk = ~clk;
	lpd_i2c_master m (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
	lpd_dimmer dut (
		.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.lamp_drive_0_out(lo[0]), .lamp_drive_0_oe(le[0]), .lamp_drive_1_out(lo[1]), .lamp_drive_1_oe(le[1]),
		.lamp_drive_2_out(lo[2]), .lamp_drive_2_oe(le[2]), .lamp_drive_3_out(lo[3]), .lamp_drive_3_oe(le[3])
	);
	// --------
	// Tasks
	// --------
	task chk(input [7:0] got, input [7:0] exp);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task snd(input [7:0] b, input e);
	begin
		m.put(b, a);
		chk({7'h00, a}, {7'h00, e});
	end
	endtask
	task wr(input [7:0] r, input [7:0] v, input s);
	begin
		m.start;
		snd(8'hc4, 1'b1);
		snd(r, 1'b1);
		snd(v, 1'b1);
		if (s)
			m.stop;
	end
	endtask
	task rd(input [7:0] r);
	begin
		m.start;
		snd(8'hc4, 1'b1);
		snd(r, 1'b1);
		m.start;
		snd(8'hc5, 1'b1);
	end
	endtask
	// Counting a whole period makes the result phase independent
	task cnt(input integer n);
	begin
		k = 0;
		repeat (n)
		begin
			@(posedge clk);
			if (le[0] === 1'b1 && lo[0] === 1'b0)
				k = k + 1;
		end
	end
	endtask
	task summarize;
	begin
		$display("mismatches %0d of %0d checks", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		#9800000;
		n_mismatch = n_mismatch + 1;
		summarize;
	end
	// --------
	// Tests
	// --------
	initial
	begin
		nrst = 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		chk({le, lo}, 8'h0f);
		rd(8'h80);
		for (i = 0; i < 13; i = i + 1)
		begin
			m.get(i == 12, d);
			chk(d, DFLT[103 - 8 * i -: 8]);
		end
		m.stop;
		for (i = 0; i < 4; i = i + 1)
		begin
			m.start;
			snd(ADRS[31 - 8 * i -: 8], ACKS[3 - i]);
			m.stop;
		end
		wr(8'h08, 8'h55, 1'b0);
		repeat (100) @(posedge clk);
		chk({le, lo}, 8'h0f);
		m.stop;
		repeat (6500) @(posedge clk);
		chk({le, lo}, 8'hf0);
		wr(8'h01, 8'h0c, 1'b1);
		wr(8'h08, 8'h00, 1'b0);
		repeat (6500) @(posedge clk);
		chk({le, lo}, 8'hff);
		m.stop;
		wr(8'h02, 8'h40, 1'b1);
		wr(8'h08, 8'h02, 1'b1);
		repeat (6500) @(posedge clk);
		cnt(6400);
		chk(8'(k / 100), 8'h10);
		chk(8'(k % 100), 8'h00);
		wr(8'h02, 8'h80, 1'b1);
		wr(8'h08, 8'h03, 1'b1);
		repeat (6500) @(posedge clk);
		cnt(51200);
		chk(8'(k / 100), 8'hf0);
		chk(8'(k % 100), 8'h00);
		wr(8'h00, 8'h09, 1'b1);
		m.start;
		snd(8'he2, 1'b1);
		m.stop;
		m.start;
		snd(8'h00, 1'b1);
		snd(8'h06, 1'b1);
		m.stop;
		repeat (10) @(posedge clk);
		chk({le, lo}, 8'h0f);
		m.start;
		snd(8'he2, 1'b0);
		m.stop;
		rd(8'h01);
		m.get(1'b1, d);
		chk(d, 8'h00);
		m.stop;
		summarize;
	end
endmodule
